// ==== rtl/bcp_pkg.sv ====
// constants, codes and state encoding for the boot command packet parser
// assumes a byte-wide receive and transmit stream on the same clock
`default_nettype none
package bcp_pkg;
  // framing bytes
  localparam logic [7:0] COMMAND_START_BYTE = 8'h01;
  localparam logic [7:0] DATA_START_BYTE = 8'h81;
  localparam logic [7:0] PACKET_END_BYTE = 8'h03;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  // general length range: code byte plus 0..255 parameter bytes
  localparam logic [15:0] LEN_MIN = 16'h0001;
  localparam logic [15:0] LEN_MAX = 16'h0100;
  localparam logic [15:0] LEN_ONE = 16'h0001;

  // command codes
  localparam int NUM_CODES = 20;
  localparam logic [7:0] CODE_INQUIRY = 8'h00;
  localparam logic [7:0] CODE_ERASE = 8'h12;
  localparam logic [7:0] CODE_WRITE = 8'h13;
  localparam logic [7:0] CODE_READ = 8'h15;
  localparam logic [7:0] CODE_CRC = 8'h18;
  localparam logic [7:0] CODE_KEY_SET = 8'h28;
  localparam logic [7:0] CODE_KEY_VERIFY = 8'h29;
  localparam logic [7:0] CODE_USER_KEY_SET = 8'h2A;
  localparam logic [7:0] CODE_USER_KEY_VERIFY = 8'h2B;
  localparam logic [7:0] CODE_LIFECYCLE_REQ = 8'h2C;
  localparam logic [7:0] CODE_AUTH = 8'h30;
  localparam logic [7:0] CODE_BAUD = 8'h34;
  localparam logic [7:0] CODE_SIGNATURE = 8'h3A;
  localparam logic [7:0] CODE_AREA_INFO = 8'h3B;
  localparam logic [7:0] CODE_BOUNDARY_SET = 8'h4E;
  localparam logic [7:0] CODE_BOUNDARY_REQ = 8'h4F;
  localparam logic [7:0] CODE_INITIALIZE = 8'h50;
  localparam logic [7:0] CODE_PARAM_SET = 8'h51;
  localparam logic [7:0] CODE_PARAM_REQ = 8'h52;
  localparam logic [7:0] CODE_LIFECYCLE_MOVE = 8'h71;

  // code table; user key entries are marked in the mask below
  localparam logic [7:0] CODE_TABLE [NUM_CODES] = '{
    CODE_INQUIRY, CODE_ERASE, CODE_WRITE, CODE_READ, CODE_CRC,
    CODE_KEY_SET, CODE_KEY_VERIFY, CODE_USER_KEY_SET, CODE_USER_KEY_VERIFY,
    CODE_LIFECYCLE_REQ, CODE_AUTH, CODE_BAUD, CODE_SIGNATURE, CODE_AREA_INFO,
    CODE_BOUNDARY_SET, CODE_BOUNDARY_REQ, CODE_INITIALIZE, CODE_PARAM_SET,
    CODE_PARAM_REQ, CODE_LIFECYCLE_MOVE};
  localparam logic [NUM_CODES-1:0] USER_KEY_MASK = 20'h00180;

  // exact lengths of commands whose length is fixed
  localparam logic [15:0] LEN_INQUIRY = 16'h0001;
  localparam logic [15:0] LEN_INITIALIZE = 16'h0003;

  // error response: response code is the command code with this bit set
  localparam logic [7:0] RES_ERROR_FLAG = 8'h80;
  localparam logic [7:0] ERR_PACKET = 8'hC1;
  localparam logic [7:0] ERR_CHECKSUM = 8'hC2;
  localparam logic [7:0] ERR_UNSUPPORTED = 8'hC3;
  localparam logic [15:0] ERR_RESP_LEN = 16'h0002;

  // error packet byte positions
  localparam logic [2:0] TX_POS_START = 3'h0;
  localparam logic [2:0] TX_POS_LEN_H = 3'h1;
  localparam logic [2:0] TX_POS_LEN_L = 3'h2;
  localparam logic [2:0] TX_POS_RES = 3'h3;
  localparam logic [2:0] TX_POS_STS = 3'h4;
  localparam logic [2:0] TX_POS_SUM = 3'h5;
  localparam logic [2:0] TX_POS_END = 3'h6;

  // buffer shape
  localparam int BUF_WIDTH = 8;
  localparam int BUF_DEPTH = 2;
  localparam int PARAM_DEPTH = 256;

  typedef enum logic [3:0] {
    ST_HUNT = 4'h0,
    ST_LEN_H = 4'h1,
    ST_LEN_L = 4'h2,
    ST_CODE = 4'h3,
    ST_PARAM = 4'h4,
    ST_SUM = 4'h5,
    ST_END = 4'h6,
    ST_CHECK = 4'h7,
    ST_DISPATCH = 4'h8,
    ST_SEND = 4'h9
  } bcp_state_type;
endpackage
`default_nettype wire

// ==== rtl/bcp_buf.sv ====
// two-entry valid/ready buffer held in flip-flops
// assumes both sides run on clk_i; drain side may stall at will
`default_nettype none
module bcp_buf #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  wire push = in_valid_i && in_ready_o;
  wire pop = out_valid_o && out_ready_i;
  wire [AW-1:0] wr_next = (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + AW'(1);
  wire [AW-1:0] rd_next = (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + AW'(1);

  // honest flags from the occupancy count
  assign in_ready_o = (count_r != FULL_COUNT);
  assign out_valid_o = (count_r != '0);
  assign out_data_o = mem_r[rd_ptr_r];

  // storage, one write port per entry
  for (genvar e = 0; e < DEPTH; e++) begin : g_entry
    always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        mem_r[e] <= '0;
      end else if (push && wr_ptr_r == AW'(e)) begin
        mem_r[e] <= in_data_i;
      end
    end
  end

  // pointers and occupancy
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) wr_ptr_r <= wr_next;
      if (pop) rd_ptr_r <= rd_next;
      if (push && !pop) count_r <= count_r + (AW+1)'(1);
      else if (pop && !push) count_r <= count_r - (AW+1)'(1);
    end
  end
endmodule
`default_nettype wire

// ==== rtl/bcp_parser.sv ====
// boot command packet parser: frames, checks and dispatches host commands
// assumes a byte receiver and transmitter on clk_i with valid/ready handshakes
//
// Contract
// RL1: command packet is start 0x01, length high/low, code, 0-255 params, sum, end.
// RL2: length, code, params and checksum byte add to zero modulo 256.
// RL3: answers go in data packets: 0x81, length, response code, data, sum, 0x03.
// RL4: while waiting, drop every byte until the command start byte arrives.
// RL5: missing end byte in final position gives a packet error answer.
// RL6: bad checksum gives a checksum error answer.
// RL7: length outside the general format range gives a packet error answer.
// RL8: unknown command code gives an unsupported command answer.
// RL9: length not matching the command's exact length gives a packet error.
// RL10: after any analysis error, no processing; return to hunting for start.
// RL11: dispatch only after all analysis checks pass.
// RL12: after a command completes, stay ready for the next command packet.
// RL13: inquiry is code 0x00 with length 0x01, no params, checksum 0xFF.
// RL14: code 0x3B is the area information request.
// RL15: code 0x18 is the memory area cyclic redundancy check.
// RL16: code 0x2C returns the current lifecycle state.
// RL17: code 0x71 moves between lifecycle states.
// RL18: user key codes 0x2A and 0x2B exist only on the first variant.
// RL19: erase 0x12, write 0x13, read 0x15.
// RL20: authentication 0x30, baud 0x34, key set 0x28, verify 0x29, signature 0x3A, init 0x50.
// RL21: parameter setting 0x51 and parameter request 0x52.
// RL22: boundary setting 0x4E and boundary request 0x4F.
// RL23: each error answer is a data packet whose response code names the error; the code sets 0x80 on the command code and names the error in the status byte.
`default_nettype none
module bcp_parser #(
  parameter bit USER_KEYS_PRESENT = 1'b1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // received byte stream
  input wire logic rx_valid_i,
  output logic rx_ready_o,
  input wire logic [7:0] rx_data_i,
  // transmitted response byte stream
  output logic tx_valid_o,
  input wire logic tx_ready_i,
  output logic [7:0] tx_data_o,
  // command dispatch
  output logic cmd_valid_o,
  input wire logic cmd_ready_i,
  output logic [7:0] cmd_code_o,
  output logic [15:0] cmd_len_o,
  // parameter readout
  input wire logic [7:0] param_idx_i,
  output logic [7:0] param_data_o,
  // status
  output logic frame_busy_o
);
  localparam int NC = bcp_pkg::NUM_CODES;

  // sequencer state
  bcp_pkg::bcp_state_type state_r;
  bcp_pkg::bcp_state_type state_nxt;

  // captured header and running sum
  logic [15:0] len_r;
  logic [7:0] code_r;
  logic [7:0] sum_r;

  // payload count and end verdict
  logic [15:0] pcount_r;
  logic end_ok_r;

  // error status and answer position
  logic [7:0] err_sts_r;
  logic [2:0] tx_pos_r;

  // parameter store and readout flop
  logic [7:0] params_r [bcp_pkg::PARAM_DEPTH];
  logic [7:0] param_data_r;

  // byte acceptance
  wire rx_take = rx_valid_i && rx_ready_o;
  // the start byte stays out of the sum
  wire [7:0] sum_add = sum_r + rx_data_i;

  // payload bookkeeping
  // a zero length carries no parameters
  wire [15:0] param_total = (len_r == 16'h0000) ? 16'h0000 : len_r - bcp_pkg::LEN_ONE;
  wire params_done = (pcount_r == param_total);
  wire param_store = rx_take && (state_r == bcp_pkg::ST_PARAM) && (pcount_r[15:8] == '0);

  // code decode, one comparator per table entry
  // an unknown code misses every entry
  logic [NC-1:0] code_hit;
  for (genvar c = 0; c < NC; c++) begin : g_code
    // user key entries vanish on the second variant
    assign code_hit[c] = (code_r == bcp_pkg::CODE_TABLE[c]) &&
                         (USER_KEYS_PRESENT || !bcp_pkg::USER_KEY_MASK[c]); // see RL18
  end
  // see RL14 see RL15 see RL16 see RL17 see RL19 see RL20 see RL21 see RL22
  wire code_known = |code_hit;

  // per-command exact length; zero means the length is not fixed here
  // only inquiry and initialize are fixed
  wire [15:0] exact_len = (code_r == bcp_pkg::CODE_INQUIRY) ? bcp_pkg::LEN_INQUIRY : // see RL13
                          (code_r == bcp_pkg::CODE_INITIALIZE) ? bcp_pkg::LEN_INITIALIZE :
                          16'h0000;

  // analysis checks, in protocol order
  // the sum holds the checksum byte, so zero is good
  wire chk_end_bad = !end_ok_r; // see RL5
  wire chk_sum_bad = (sum_r != bcp_pkg::ZERO_BYTE); // see RL2 see RL6
  wire chk_len_bad = (len_r < bcp_pkg::LEN_MIN) || (len_r > bcp_pkg::LEN_MAX); // see RL7
  wire chk_code_bad = !code_known; // see RL8
  wire chk_exact_bad = (exact_len != 16'h0000) && (len_r != exact_len); // see RL9
  wire any_err = chk_end_bad || chk_sum_bad || chk_len_bad || chk_code_bad || chk_exact_bad;

  // first failing check names the status
  wire [7:0] err_sel = chk_end_bad ? bcp_pkg::ERR_PACKET :
                       chk_sum_bad ? bcp_pkg::ERR_CHECKSUM :
                       chk_len_bad ? bcp_pkg::ERR_PACKET :
                       chk_code_bad ? bcp_pkg::ERR_UNSUPPORTED :
                       bcp_pkg::ERR_PACKET;

  // error data packet fields
  // length: response code plus one status
  wire [7:0] res_byte = code_r | bcp_pkg::RES_ERROR_FLAG; // see RL23
  wire [7:0] resp_sum = 8'h00 - (bcp_pkg::ERR_RESP_LEN[15:8] + bcp_pkg::ERR_RESP_LEN[7:0] +
                                 res_byte + err_sts_r); // see RL2 see RL3
  logic [7:0] tx_byte;
  always_comb begin
    case (tx_pos_r)
      bcp_pkg::TX_POS_START: tx_byte = bcp_pkg::DATA_START_BYTE; // see RL3
      bcp_pkg::TX_POS_LEN_H: tx_byte = bcp_pkg::ERR_RESP_LEN[15:8];
      bcp_pkg::TX_POS_LEN_L: tx_byte = bcp_pkg::ERR_RESP_LEN[7:0];
      bcp_pkg::TX_POS_RES: tx_byte = res_byte;
      bcp_pkg::TX_POS_STS: tx_byte = err_sts_r;
      bcp_pkg::TX_POS_SUM: tx_byte = resp_sum;
      bcp_pkg::TX_POS_END: tx_byte = bcp_pkg::PACKET_END_BYTE;
      default: tx_byte = bcp_pkg::ZERO_BYTE;
    endcase
  end

  // response buffer: a stalled transmitter stalls the sender
  // two entries let the sender run ahead
  wire send_active = (state_r == bcp_pkg::ST_SEND);
  wire buf_ready;
  wire tx_push = send_active && buf_ready;
  // hunting resumes once the end byte is queued
  wire tx_last = tx_push && (tx_pos_r == bcp_pkg::TX_POS_END);

  bcp_buf #(
    .WIDTH(bcp_pkg::BUF_WIDTH),
    .DEPTH(bcp_pkg::BUF_DEPTH)
  ) u_resp_buf (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .in_valid_i(send_active),
    .in_ready_o(buf_ready),
    .in_data_i(tx_byte),
    .out_valid_o(tx_valid_o),
    .out_ready_i(tx_ready_i),
    .out_data_o(tx_data_o)
  );

  // receive stalls while checking, dispatching or answering
  // one packet at a time keeps the header stable
  assign rx_ready_o = (state_r != bcp_pkg::ST_CHECK) && (state_r != bcp_pkg::ST_DISPATCH) &&
                      (state_r != bcp_pkg::ST_SEND);

  // dispatch fields stand until taken
  assign cmd_valid_o = (state_r == bcp_pkg::ST_DISPATCH);
  assign cmd_code_o = code_r;
  assign cmd_len_o = len_r;

  // readout and status
  assign param_data_o = param_data_r;
  assign frame_busy_o = (state_r != bcp_pkg::ST_HUNT);

  // packet framing and analysis sequence
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      // drop all but the start byte
      bcp_pkg::ST_HUNT: begin
        if (rx_take && rx_data_i == bcp_pkg::COMMAND_START_BYTE) begin
          state_nxt = bcp_pkg::ST_LEN_H; // see RL4 see RL1
        end
      end
      // length, high byte first
      bcp_pkg::ST_LEN_H: begin
        if (rx_take) begin
          state_nxt = bcp_pkg::ST_LEN_L;
        end
      end
      // low byte completes the length
      bcp_pkg::ST_LEN_L: begin
        if (rx_take) begin
          state_nxt = bcp_pkg::ST_CODE;
        end
      end
      // no parameters: straight to the sum
      bcp_pkg::ST_CODE: begin
        if (rx_take) begin
          state_nxt = params_done ? bcp_pkg::ST_SUM : bcp_pkg::ST_PARAM;
        end
      end
      // last parameter moves on
      bcp_pkg::ST_PARAM: begin
        if (rx_take && (pcount_r + 16'h0001) == param_total) begin
          state_nxt = bcp_pkg::ST_SUM;
        end
      end
      // checksum byte
      bcp_pkg::ST_SUM: begin
        if (rx_take) begin
          state_nxt = bcp_pkg::ST_END;
        end
      end
      // end byte closes the frame
      bcp_pkg::ST_END: begin
        if (rx_take) begin
          state_nxt = bcp_pkg::ST_CHECK;
        end
      end
      // one cycle of analysis
      bcp_pkg::ST_CHECK: begin
        state_nxt = any_err ? bcp_pkg::ST_SEND : bcp_pkg::ST_DISPATCH; // see RL11 see RL10
      end
      // hold until the processor takes it
      bcp_pkg::ST_DISPATCH: begin
        if (cmd_ready_i) begin
          state_nxt = bcp_pkg::ST_HUNT; // see RL12
        end
      end
      // answer the error, then hunt
      bcp_pkg::ST_SEND: begin
        if (tx_last) begin
          state_nxt = bcp_pkg::ST_HUNT; // see RL10
        end
      end
      // stray codes fall back to hunting
      default: begin
        state_nxt = bcp_pkg::ST_HUNT;
      end
    endcase
  end

  // state register
  // reset lands in hunting
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_r <= bcp_pkg::ST_HUNT;
    end else begin
      state_r <= state_nxt;
    end
  end

  // header fields and running checksum
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      len_r <= '0;
      code_r <= '0;
      sum_r <= '0;
      end_ok_r <= 1'b0;
    end else if (rx_take) begin
      case (state_r)
        // a start byte clears the sum
        bcp_pkg::ST_HUNT: begin
          sum_r <= bcp_pkg::ZERO_BYTE;
        end
        // high length byte first
        bcp_pkg::ST_LEN_H: begin
          len_r[15:8] <= rx_data_i;
          sum_r <= sum_add;
        end
        bcp_pkg::ST_LEN_L: begin
          len_r[7:0] <= rx_data_i;
          sum_r <= sum_add;
        end
        bcp_pkg::ST_CODE: begin
          code_r <= rx_data_i;
          sum_r <= sum_add;
        end
        bcp_pkg::ST_PARAM, bcp_pkg::ST_SUM: begin
          sum_r <= sum_add; // see RL2
        end
        // keep the end verdict for the check
        bcp_pkg::ST_END: begin
          end_ok_r <= (rx_data_i == bcp_pkg::PACKET_END_BYTE); // see RL5
        end
        default: begin
          sum_r <= sum_r;
        end
      endcase
    end
  end

  // parameter counter
  // counts past the store so long frames still end
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pcount_r <= '0;
    end else if (state_r == bcp_pkg::ST_HUNT) begin
      pcount_r <= '0;
    end else if (rx_take && state_r == bcp_pkg::ST_PARAM) begin
      pcount_r <= pcount_r + 16'h0001;
    end
  end

  // parameter storage, one entry per index
  // bytes past the last entry are not kept
  for (genvar p = 0; p < bcp_pkg::PARAM_DEPTH; p++) begin : g_param
    always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        params_r[p] <= '0;
      end else if (param_store && pcount_r[7:0] == 8'(p)) begin
        params_r[p] <= rx_data_i;
      end
    end
  end

  // registered parameter readout
  // data follows the index by one cycle
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      param_data_r <= '0;
    end else begin
      param_data_r <= params_r[param_idx_i];
    end
  end

  // error status latch and response byte position
  // status stays frozen for the whole answer
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      err_sts_r <= '0;
      tx_pos_r <= bcp_pkg::TX_POS_START;
    end else if (state_r == bcp_pkg::ST_CHECK) begin
      err_sts_r <= err_sel; // see RL23
      tx_pos_r <= bcp_pkg::TX_POS_START;
    end else if (tx_push) begin
      // each queued byte steps the position
      tx_pos_r <= tx_pos_r + 3'h1;
    end
  end
endmodule
`default_nettype wire

// ==== sim/bcp_parser_props.sv ====
// assertion checker for the boot command packet parser, bound to its top ports
// assumes one clock domain with an active-low asynchronous reset
`default_nettype none
module bcp_parser_props #(
  parameter bit USER_KEYS_PRESENT = 1'b1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // byte streams
  input wire logic rx_valid_i,
  input wire logic rx_ready_o,
  input wire logic [7:0] rx_data_i,
  input wire logic tx_valid_o,
  input wire logic tx_ready_i,
  input wire logic [7:0] tx_data_o,
  // dispatch and status
  input wire logic cmd_valid_o,
  input wire logic cmd_ready_i,
  input wire logic [7:0] cmd_code_o,
  input wire logic [15:0] cmd_len_o,
  input wire logic frame_busy_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // a byte taken while hunting for the start byte
  wire logic hunt_take = !frame_busy_o && rx_valid_i && rx_ready_o;
  a_hunt_ready: assert property (!frame_busy_o |-> rx_ready_o)
    else $error("bytes refused while hunting");
  a_junk_dropped: assert property (hunt_take && rx_data_i != 8'h01 |=> !frame_busy_o)
    else $error("frame opened by a non-start byte");
  a_start_opens: assert property (hunt_take && rx_data_i == 8'h01 |=> frame_busy_o)
    else $error("start byte did not open a frame");
  a_cmd_stands: assert property (cmd_valid_o && !cmd_ready_i |=>
    cmd_valid_o && $stable(cmd_code_o) && $stable(cmd_len_o))
    else $error("dispatch dropped or changed before taken");
  a_cmd_done: assert property (cmd_valid_o && cmd_ready_i |=>
    !cmd_valid_o && !frame_busy_o && rx_ready_o)
    else $error("no return to hunting after dispatch");
  a_disp_no_rx: assert property (cmd_valid_o |-> !rx_ready_o && frame_busy_o)
    else $error("bytes taken during dispatch");
  a_len_range: assert property (cmd_valid_o |->
    cmd_len_o >= 16'h0001 && cmd_len_o <= 16'h0100)
    else $error("dispatched length out of range");
  a_inquiry_len: assert property (cmd_valid_o && cmd_code_o == 8'h00 |->
    cmd_len_o == 16'h0001)
    else $error("inquiry dispatched with wrong length");
  a_init_len: assert property (cmd_valid_o && cmd_code_o == 8'h50 |->
    cmd_len_o == 16'h0003)
    else $error("initialize dispatched with wrong length");
  a_user_keys: assert property (cmd_valid_o && !USER_KEYS_PRESENT |->
    cmd_code_o != 8'h2A && cmd_code_o != 8'h2B)
    else $error("user key code dispatched on second variant");
  a_tx_stands: assert property (tx_valid_o && !tx_ready_i |=>
    tx_valid_o && $stable(tx_data_o))
    else $error("response byte lost while stalled");
endmodule
bind bcp_parser bcp_parser_props #(.USER_KEYS_PRESENT(USER_KEYS_PRESENT)) i_props (
  .clk_i, .reset_n_i, .rx_valid_i, .rx_ready_o, .rx_data_i, .tx_valid_o, .tx_ready_i,
  .tx_data_o, .cmd_valid_o, .cmd_ready_i, .cmd_code_o, .cmd_len_o, .frame_busy_o);
`default_nettype wire

// ==== sim/bcp_host_model.sv ====
// host programming tool model: sends framed bytes, collects response bytes
// assumes the parser's byte streams on the same clock; sink may stall
`default_nettype none
module bcp_host_model (
  // clock
  input wire logic clk_i,
  // bytes towards the parser
  output logic rx_valid_o,
  input wire logic rx_ready_i,
  output logic [7:0] rx_data_o,
  // bytes from the parser
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  input wire logic [7:0] tx_data_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got_q[$];
  int stall_n = 0;
  int cyc = 0;
  initial begin
    rx_valid_o = 1'b0;
    rx_data_o = 8'h00;
    tx_ready_o = 1'b1;
  end
  // collect response bytes on the taking edge
  always @(posedge clk_i) begin
    if (tx_valid_i && tx_ready_o) got_q.push_back(tx_data_i);
  end
  // ready every stall_n cycles; 0 always ready, negative never
  always @(negedge clk_i) begin
    cyc = cyc + 1;
    tx_ready_o = (stall_n == 0) || (stall_n > 0 && cyc % stall_n == 0);
  end
  // each byte held until taken; idle line shows the inverse of the last byte
  task automatic send_all(input logic [7:0] q[$]);
    foreach (q[i]) begin
      @(negedge clk_i);
      rx_valid_o = 1'b1;
      rx_data_o = q[i];
      while (rx_ready_i !== 1'b1) @(negedge clk_i);
      @(posedge clk_i);
    end
    @(negedge clk_i);
    rx_valid_o = 1'b0;
    rx_data_o = ~rx_data_o;
  endtask
endmodule
`default_nettype wire

// ==== sim/bcp_parser_tb_top.sv ====
// self-checking bench: both parser variants, each driven by a host model
// assumes the checker binds itself to every parser instance
`default_nettype none
module bcp_parser_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic cmd_ready_i = 1'b0;
  logic [7:0] param_idx_i = 8'h00;
  wire logic rx_valid, rx_ready, tx_valid, tx_ready, cmd_valid, busy;
  wire logic rx_valid2, rx_ready2, tx_valid2, tx_ready2, cmd_valid2;
  wire logic [7:0] rx_data, tx_data, cmd_code, param_data, rx_data2, tx_data2;
  wire logic [15:0] cmd_len;
  int err_count = 0;
  int n_compared = 0;
  int cycles = 0;
  int n_disp = 0;
  always #12.5 clk_i = ~clk_i;
  bcp_parser #(.USER_KEYS_PRESENT(1'b1)) i_dut (.clk_i, .reset_n_i, .rx_valid_i(rx_valid),
    .rx_ready_o(rx_ready), .rx_data_i(rx_data), .tx_valid_o(tx_valid), .tx_ready_i(tx_ready),
    .tx_data_o(tx_data), .cmd_valid_o(cmd_valid), .cmd_ready_i, .cmd_code_o(cmd_code),
    .cmd_len_o(cmd_len), .param_idx_i, .param_data_o(param_data), .frame_busy_o(busy));
  bcp_parser #(.USER_KEYS_PRESENT(1'b0)) i_dut2 (.clk_i, .reset_n_i, .rx_valid_i(rx_valid2),
    .rx_ready_o(rx_ready2), .rx_data_i(rx_data2), .tx_valid_o(tx_valid2),
    .tx_ready_i(tx_ready2), .tx_data_o(tx_data2), .cmd_valid_o(cmd_valid2), .cmd_ready_i,
    .cmd_code_o(), .cmd_len_o(), .param_idx_i, .param_data_o(), .frame_busy_o());
  bcp_host_model i_host (.clk_i, .rx_valid_o(rx_valid), .rx_ready_i(rx_ready),
    .rx_data_o(rx_data), .tx_valid_i(tx_valid), .tx_ready_o(tx_ready), .tx_data_i(tx_data));
  bcp_host_model i_host2 (.clk_i, .rx_valid_o(rx_valid2), .rx_ready_i(rx_ready2),
    .rx_data_o(rx_data2), .tx_valid_i(tx_valid2), .tx_ready_o(tx_ready2),
    .tx_data_i(tx_data2));
  // count cycles offering a dispatch and cut a hang short
  always @(posedge clk_i) begin
    cycles++;
    if (cmd_valid || cmd_valid2) n_disp++;
    if (cycles == 20000) begin
      err_count++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    if (err_count == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    n_compared++;
    if (s !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, s);
      err_count++;
    end
  endtask
  // frame: start, length high/low, code, params A1.., checksum (+bad), end byte
  task automatic build(input logic [15:0] len, input logic [7:0] code, input logic [7:0] bad,
                       input logic [7:0] endb, output logic [7:0] q[$]);
    logic [7:0] s;
    s = len[15:8] + len[7:0] + code;
    q = {8'h01, len[15:8], len[7:0], code};
    for (int i = 1; i < len; i++) begin
      q.push_back(8'hA0 + 8'(i));
      s = s + 8'hA0 + 8'(i);
    end
    q.push_back(8'h00 - s + bad);
    q.push_back(endb);
  endtask
  // wait for a dispatch, check it and the first parameter, then accept it late
  task automatic take_cmd(input logic [7:0] code, input logic [15:0] len);
    int k;
    k = 0;
    while (cmd_valid !== 1'b1 && k < 300) begin
      @(negedge clk_i);
      k++;
    end
    chk("cmd valid", 16'h0001, 16'(cmd_valid));
    chk("cmd code", 16'(code), 16'(cmd_code));
    chk("cmd len", len, cmd_len);
    param_idx_i = 8'h00;
    @(negedge clk_i);
    if (len > 16'h0001) chk("param", 16'h00A1, 16'(param_data));
    cmd_ready_i = 1'b1;
    @(negedge clk_i);
    cmd_ready_i = 1'b0;
  endtask
  // error answer: 81 00 02 code|80 status sum 03
  task automatic expect_err(input logic [7:0] code, input logic [7:0] sts,
                            ref logic [7:0] g[$]);
    logic [7:0] ex[7];
    int k;
    ex = '{8'h81, 8'h00, 8'h02, code | 8'h80, sts, 8'h00 - (8'h82 + code + sts), 8'h03};
    k = 0;
    while (g.size() < 7 && k < 600) begin
      @(negedge clk_i);
      k++;
    end
    chk("tx count", 16'h0007, 16'(g.size()));
    for (int i = 0; i < 7 && i < g.size(); i++) chk("tx byte", 16'(ex[i]), 16'(g[i]));
    g.delete();
  endtask
  // junk before the start byte is dropped, then an inquiry dispatches silently
  task automatic t_hunt_inquiry();
    i_host.send_all({8'h55, 8'h03, 8'h81, 8'h01, 8'h00, 8'h01, 8'h00, 8'hFF, 8'h03});
    take_cmd(8'h00, 16'h0001);
    chk("busy", 16'h0000, 16'(busy));
    chk("tx none", 16'h0000, 16'(i_host.got_q.size()));
  endtask
  // every defined code dispatches, frames back to back
  task automatic t_code_sweep();
    logic [7:0] c[20] = '{8'h00, 8'h12, 8'h13, 8'h15, 8'h18, 8'h28, 8'h29, 8'h2A, 8'h2B,
      8'h2C, 8'h30, 8'h34, 8'h3A, 8'h3B, 8'h4E, 8'h4F, 8'h50, 8'h51, 8'h52, 8'h71};
    logic [7:0] q[$];
    logic [15:0] len;
    for (int i = 0; i < 20; i++) begin
      len = (c[i] == 8'h50) ? 16'h0003 : 16'h0001;
      build(len, c[i], 8'h00, 8'h03, q);
      i_host.send_all(q);
      take_cmd(c[i], len);
    end
  endtask
  // each analysis error answers and never dispatches; the sink stalls first
  task automatic t_errors();
    logic [15:0] l[6] = '{16'h0001, 16'h0000, 16'h0101, 16'h0001, 16'h0002, 16'h0002};
    logic [7:0] c[6] = '{8'h00, 8'h00, 8'h00, 8'h77, 8'h00, 8'h50};
    logic [7:0] b[6] = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] s[6] = '{8'hC2, 8'hC1, 8'hC1, 8'hC3, 8'hC1, 8'hC1};
    logic [7:0] q[$];
    int d0;
    d0 = n_disp;
    i_host.stall_n = -1;
    build(16'h0001, 8'h00, 8'h00, 8'h55, q);
    i_host.send_all(q);
    repeat (12) @(negedge clk_i);
    chk("tx held", 16'h0001, 16'(tx_valid));
    i_host.stall_n = 3;
    expect_err(8'h00, 8'hC1, i_host.got_q);
    for (int i = 0; i < 6; i++) begin
      build(l[i], c[i], b[i], 8'h03, q);
      i_host.send_all(q);
      expect_err(c[i], s[i], i_host.got_q);
    end
    i_host.stall_n = 0;
    chk("no dispatch", 16'(d0), 16'(n_disp));
    i_host.send_all({8'h01, 8'h00, 8'h01, 8'h00, 8'hFF, 8'h03});
    take_cmd(8'h00, 16'h0001);
  endtask
  // second variant refuses both user key codes
  task automatic t_variant_two();
    logic [7:0] q[$];
    int d0;
    d0 = n_disp;
    for (int i = 0; i < 2; i++) begin
      build(16'h0001, 8'h2A + 8'(i), 8'h00, 8'h03, q);
      i_host2.send_all(q);
      expect_err(8'h2A + 8'(i), 8'hC3, i_host2.got_q);
    end
    chk("no dispatch", 16'(d0), 16'(n_disp));
  endtask
  // reset, then the scenarios in turn
  initial begin
    repeat (6) @(posedge clk_i);
    @(negedge clk_i);
    reset_n_i = 1'b1;
    t_hunt_inquiry();
    t_code_sweep();
    t_errors();
    t_variant_two();
    report_and_stop();
  end
endmodule
`default_nettype wire
